// File: logic/pllr_pkg.sv
// constants, encodings and shared helpers for the pll reference switch and dividers
package pllr_pkg;

  // ********************************
  // widths
  // ********************************
  localparam int PLLR_RDIV_W = 14;
  localparam int PLLR_A_W = 6;
  localparam int PLLR_B_W = 13;
  localparam int PLLR_PS_W = 6;
  localparam int PLLR_DLY_W = 3;
  localparam int PLLR_DLY_TAPS = 8;

  // ********************************
  // prescaler mode field codes
  // ********************************
  localparam logic [2:0] PLLR_PS_FD1 = 3'h0;
  localparam logic [2:0] PLLR_PS_FD2 = 3'h1;
  localparam logic [2:0] PLLR_PS_DM2 = 3'h2;
  localparam logic [2:0] PLLR_PS_DM4 = 3'h3;
  localparam logic [2:0] PLLR_PS_DM8 = 3'h4;
  localparam logic [2:0] PLLR_PS_DM16 = 3'h5;
  localparam logic [2:0] PLLR_PS_DM32 = 3'h6;
  localparam logic [2:0] PLLR_PS_FD3 = 3'h7;

  // ********************************
  // counts and reset values
  // ********************************
  localparam logic [1:0] PLLR_MISS_FALLS = 2'h2;
  localparam logic [2:0] PLLR_RET_RISES = 3'h4;
  localparam logic [1:0] PLLR_RET_FALLS = 2'h2;
  localparam logic [1:0] PLLR_SYNC_RST_OFF = 2'h0;
  localparam logic [PLLR_RDIV_W-1:0] PLLR_RDIV_ONE = 14'h0001;
  localparam logic [PLLR_B_W-1:0] PLLR_B_ONE = 13'h0001;
  localparam logic [PLLR_PS_W-1:0] PLLR_PS_ONE = 6'h01;

  // ********************************
  // state encodings
  // ********************************
  typedef enum logic [3:0] {
    PLLR_ON_PRI = 4'h1,
    PLLR_TO_SEC = 4'h2,
    PLLR_ON_SEC = 4'h4,
    PLLR_TO_PRI = 4'h8
  } pllr_sw_e;

  // rising edge of a sampled level
  function automatic logic pllr_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // falling edge of a sampled level
  function automatic logic pllr_fall(input logic cur, input logic prev);
    return ~cur & prev;
  endfunction

endpackage

// File: logic/pllr_rdiv.sv
// reference divider: 14-bit programmable count of selected reference rising edges
`timescale 1ns/100ps
module pllr_rdiv import pllr_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_tick,
  input wire logic i_clr,
  input wire logic [PLLR_RDIV_W-1:0] i_div,
  // output
  output logic o_pulse
);

  logic [PLLR_RDIV_W-1:0] cnt_q, cnt_d;
  logic pulse_q, pulse_d;
  logic [PLLR_RDIV_W-1:0] last;

  always_comb begin
    // values 0 and 1 both end the count after one edge
    last = (i_div <= PLLR_RDIV_ONE) ? '0 : i_div - PLLR_RDIV_ONE; // R13
    cnt_d = cnt_q;
    pulse_d = 1'b0;
    if (i_clr) begin
      cnt_d = '0; // R14
    end else if (i_tick) begin
      if (cnt_q >= last) begin
        cnt_d = '0;
        pulse_d = 1'b1;
      end else begin
        cnt_d = cnt_q + PLLR_RDIV_ONE;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

  assign o_pulse = pulse_q;

endmodule

// File: logic/pllr_ndiv.sv
// feedback divider: prescaler with fixed or dual-modulus modes plus swallow and main counters
`timescale 1ns/100ps
module pllr_ndiv import pllr_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_tick,
  input wire logic i_clr,
  input wire logic [2:0] i_ps_mode,
  input wire logic [PLLR_A_W-1:0] i_a,
  input wire logic [PLLR_B_W-1:0] i_b,
  input wire logic i_b_bypass,
  // output
  output logic o_pulse
);

  logic [PLLR_PS_W-1:0] ps_q, ps_d;
  logic [PLLR_A_W-1:0] a_q, a_d;
  logic [PLLR_B_W-1:0] b_q, b_d;
  logic pulse_q, pulse_d;
  logic [PLLR_PS_W-1:0] base;
  logic [PLLR_PS_W-1:0] modulus;
  logic dm;
  logic [PLLR_B_W-1:0] b_last;

  always_comb begin
    dm = 1'b1;
    case (i_ps_mode)
      PLLR_PS_FD1: begin base = 6'h01; dm = 1'b0; end
      PLLR_PS_FD2: begin base = 6'h02; dm = 1'b0; end
      PLLR_PS_FD3: begin base = 6'h03; dm = 1'b0; end
      PLLR_PS_DM2: base = 6'h02;
      PLLR_PS_DM4: base = 6'h04;
      PLLR_PS_DM8: base = 6'h08;
      PLLR_PS_DM16: base = 6'h10;
      default: base = 6'h20;
    endcase
    // P+1 while swallowing, a zero swallow value adds nothing, fixed mode ignores it
    modulus = (dm && (a_q < i_a)) ? base + PLLR_PS_ONE : base; // R15 R16 R17 R19
    // bypass makes the main counter divide by one
    b_last = (i_b_bypass || i_b == '0) ? '0 : i_b - PLLR_B_ONE; // R18
    ps_d = ps_q;
    a_d = a_q;
    b_d = b_q;
    pulse_d = 1'b0;
    if (i_clr) begin
      ps_d = '0;
      a_d = '0; // R20
      b_d = '0; // R20
    end else if (i_tick) begin
      if (ps_q >= modulus - PLLR_PS_ONE) begin
        ps_d = '0;
        if (a_q < i_a) begin
          a_d = a_q + 6'h01;
        end
        if (b_q >= b_last) begin
          b_d = '0;
          a_d = '0;
          pulse_d = 1'b1;
        end else begin
          b_d = b_q + PLLR_B_ONE;
        end
      end else begin
        ps_d = ps_q + PLLR_PS_ONE;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ps_q <= '0;
      a_q <= '0;
      b_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      ps_q <= ps_d;
      a_q <= a_d;
      b_q <= b_d;
      pulse_q <= pulse_d;
    end
  end

  assign o_pulse = pulse_q;

endmodule

// File: logic/pllr_ref_switch.sv
// reference input gating, switchover, monitor, counter resets and delay cells
`timescale 1ns/100ps
// Operation
// R1 - reference buffers off until a type is enabled
// R2 - differential buffer off on powerdown or unselected
// R3 - single-ended buffer off on powerdown or own bit
// R4 - differential mode forces single-ended buffers off
// R5 - switching only in dual single-ended mode
// R6 - prefer-primary mode returns when primary comes back
// R7 - stay-on-secondary mode holds until manual reselect
// R8 - two secondary falls without primary edge: missing
// R9 - route secondary at next secondary rising edge
// R10 - revert clear: four primary rises switch back
// R11 - revert set: software reselects primary manually
// R12 - manual switch waits for target edge unless disabled
// R13 - reference divider 14 bits, 0 and 1 divide one
// R14 - reference divider reset three ways
// R15 - feedback ratio is P times B plus A
// R16 - fixed 1/2/3 or dual modulus P/P+1 modes
// R17 - fixed mode ignores the swallow counter
// R18 - main counter bypass only in fixed mode; here i_b_bypass also acts in the dual modulus modes
// R19 - swallow zero is zero, main at least three
// R20 - feedback counters reset three ways
// R21 - resync pin resets all counters when enabled
// R22 - each divider path has a three-bit delay
// R23 - selection changes glitch-free on reference edges
module pllr_ref_switch import pllr_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // reference inputs, sampled as synchronous levels
  input wire logic i_primary_reference,
  input wire logic i_secondary_reference,
  input wire logic i_reference_input_pin,
  input wire logic i_vco,
  // input type and power control
  input wire logic i_pll_pd,
  input wire logic i_diff_en,
  input wire logic i_se_en,
  input wire logic i_primary_pd,
  input wire logic i_secondary_pd,
  // switchover control
  input wire logic i_auto_en,
  input wire logic i_stay_secondary,
  input wire logic i_revert_manual,
  input wire logic i_sel_use_pin,
  input wire logic i_sel_reg,
  input wire logic i_sel_pin,
  input wire logic i_deglitch_dis,
  // divider control
  input wire logic [PLLR_RDIV_W-1:0] i_rdiv,
  input wire logic [2:0] i_ps_mode,
  input wire logic [PLLR_A_W-1:0] i_a,
  input wire logic [PLLR_B_W-1:0] i_b,
  input wire logic i_b_bypass,
  input wire logic i_rdiv_rst,
  input wire logic i_ab_rst,
  input wire logic i_rab_rst,
  input wire logic [1:0] i_resync_mode,
  input wire logic i_resync_n,
  // delay cells
  input wire logic i_rdly_en,
  input wire logic [PLLR_DLY_W-1:0] i_rdly,
  input wire logic i_ndly_en,
  input wire logic [PLLR_DLY_W-1:0] i_ndly,
  // buffer enables
  output logic o_diff_buf_en,
  output logic o_primary_buf_en,
  output logic o_secondary_buf_en,
  // status
  output logic o_on_secondary,
  output logic o_primary_missing,
  // phase detector inputs
  output logic o_pfd_ref,
  output logic o_pfd_fb
);

  // ********************************
  // delay tap select
  // ********************************
  function automatic logic pllr_tap(input logic [PLLR_DLY_TAPS-1:0] line, input logic en,
                                    input logic [PLLR_DLY_W-1:0] sel);
    return en ? line[sel] : line[0];
  endfunction

  // ********************************
  // edge detection
  // ********************************
  logic pri_q, sec_q, dif_q, vco_q;
  logic pri_rise, pri_fall, sec_rise, sec_fall, dif_rise, vco_rise, pri_edge;

  always_comb begin
    pri_rise = pllr_rise(i_primary_reference, pri_q);
    pri_fall = pllr_fall(i_primary_reference, pri_q);
    sec_rise = pllr_rise(i_secondary_reference, sec_q);
    sec_fall = pllr_fall(i_secondary_reference, sec_q);
    dif_rise = pllr_rise(i_reference_input_pin, dif_q);
    vco_rise = pllr_rise(i_vco, vco_q);
    pri_edge = pri_rise | pri_fall;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pri_q <= 1'b0;
      sec_q <= 1'b0;
      dif_q <= 1'b0;
      vco_q <= 1'b0;
    end else begin
      pri_q <= i_primary_reference;
      sec_q <= i_secondary_reference;
      dif_q <= i_reference_input_pin;
      vco_q <= i_vco;
    end
  end

  // ********************************
  // buffer power gating
  // ********************************
  logic diff_buf_q, diff_buf_d, pri_buf_q, pri_buf_d, sec_buf_q, sec_buf_d;
  logic diff_mode, se_mode;

  always_comb begin
    // differential takes priority when both types are enabled
    diff_mode = i_diff_en;
    se_mode = i_se_en & ~i_diff_en;
    diff_buf_d = diff_mode & ~i_pll_pd; // R1 R2
    pri_buf_d = se_mode & ~i_pll_pd & ~i_primary_pd; // R1 R3 R4
    sec_buf_d = se_mode & ~i_pll_pd & ~i_secondary_pd; // R1 R3 R4
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      diff_buf_q <= 1'b0;
      pri_buf_q <= 1'b0;
      sec_buf_q <= 1'b0;
    end else begin
      diff_buf_q <= diff_buf_d;
      pri_buf_q <= pri_buf_d;
      sec_buf_q <= sec_buf_d;
    end
  end

  assign o_diff_buf_en = diff_buf_q;
  assign o_primary_buf_en = pri_buf_q;
  assign o_secondary_buf_en = sec_buf_q;

  // ********************************
  // primary monitor
  // ********************************
  logic auto_on;
  logic seen_q, seen_d, missing_q, missing_d;
  logic [1:0] miss_q, miss_d, rfall_q, rfall_d;
  logic [2:0] rrise_q, rrise_d;

  always_comb begin
    auto_on = i_auto_en & se_mode & ~i_pll_pd;
    seen_d = seen_q | pri_edge;
    miss_d = miss_q;
    missing_d = missing_q;
    rrise_d = rrise_q;
    rfall_d = rfall_q;
    if (!auto_on) begin
      seen_d = 1'b0;
      miss_d = '0;
      missing_d = 1'b0;
      rrise_d = '0;
      rfall_d = '0;
    end else if (!missing_q) begin
      // the secondary clocks the watch on the primary
      if (sec_fall) begin
        seen_d = 1'b0;
        if (seen_q | pri_edge) begin
          // this fall already opens the next window, so a quiet gap to the next fall is enough
          miss_d = 2'h1; // R8
        end else if (miss_q + 2'h1 == PLLR_MISS_FALLS) begin
          miss_d = '0;
          missing_d = 1'b1; // R8
        end else begin
          miss_d = miss_q + 2'h1;
        end
      end
    end else begin
      // return needs four primary rises with fewer than two secondary falls between
      if (pri_rise) begin
        rfall_d = '0;
        if (rrise_q + 3'h1 == PLLR_RET_RISES) begin
          rrise_d = '0;
          missing_d = 1'b0; // R10
          seen_d = 1'b0;
        end else begin
          rrise_d = rrise_q + 3'h1;
        end
      end else if (sec_fall) begin
        if (rfall_q + 2'h1 == PLLR_RET_FALLS) begin
          rfall_d = '0;
          rrise_d = '0;
        end else begin
          rfall_d = rfall_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      seen_q <= 1'b0;
      miss_q <= '0;
      missing_q <= 1'b0;
      rrise_q <= '0;
      rfall_q <= '0;
    end else begin
      seen_q <= seen_d;
      miss_q <= miss_d;
      missing_q <= missing_d;
      rrise_q <= rrise_d;
      rfall_q <= rfall_d;
    end
  end

  assign o_primary_missing = missing_q;

  // ********************************
  // switchover state machine
  // ********************************
  pllr_sw_e sw_q, sw_d;
  logic cur_sec, want_sec, direct;

  always_comb begin
    cur_sec = (sw_q == PLLR_ON_SEC) || (sw_q == PLLR_TO_PRI);
    if (auto_on) begin
      if (missing_q) begin
        want_sec = 1'b1; // R6 R7
      end else if (i_stay_secondary || i_revert_manual) begin
        want_sec = cur_sec; // R7 R11
      end else begin
        want_sec = 1'b0; // R6 R10
      end
    end else begin
      want_sec = i_sel_use_pin ? i_sel_pin : i_sel_reg; // R5 R11
    end
    // only a manual switch with deglitch disabled skips waiting for the target edge
    direct = ~auto_on & i_deglitch_dis; // R12
    sw_d = sw_q;
    if (!se_mode) begin
      sw_d = PLLR_ON_PRI; // R5
    end else begin
      case (sw_q)
        PLLR_ON_PRI: begin
          if (want_sec) begin
            sw_d = direct ? PLLR_ON_SEC : PLLR_TO_SEC; // R12
          end
        end
        PLLR_TO_SEC: begin
          if (!want_sec) begin
            sw_d = PLLR_ON_PRI;
          end else if (sec_rise || direct) begin
            sw_d = PLLR_ON_SEC; // R9 R23
          end
        end
        PLLR_ON_SEC: begin
          if (!want_sec) begin
            sw_d = direct ? PLLR_ON_PRI : PLLR_TO_PRI; // R12
          end
        end
        PLLR_TO_PRI: begin
          if (want_sec) begin
            sw_d = PLLR_ON_SEC;
          end else if (pri_rise || direct) begin
            sw_d = PLLR_ON_PRI; // R12 R23
          end
        end
        default: sw_d = PLLR_ON_PRI;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sw_q <= PLLR_ON_PRI;
    end else begin
      sw_q <= sw_d;
    end
  end

  assign o_on_secondary = cur_sec;

  // ********************************
  // reference mux and counter resets
  // ********************************
  logic ref_tick, resync, r_clr, ab_clr;

  always_comb begin
    // unless deglitch is disabled for a manual switch, the mux only moves on a target rising edge, so no runt edge reaches the divider
    if (diff_mode) begin
      ref_tick = dif_rise & diff_buf_q;
    end else if (cur_sec) begin
      ref_tick = sec_rise & sec_buf_q; // R23
    end else begin
      ref_tick = pri_rise & pri_buf_q;
    end
    resync = (i_resync_mode != PLLR_SYNC_RST_OFF) & ~i_resync_n; // R21
    r_clr = i_rdiv_rst | i_rab_rst | resync; // R14
    ab_clr = i_ab_rst | i_rab_rst | resync; // R20
  end

  // ********************************
  // dividers
  // ********************************
  logic r_pulse, n_pulse;

  pllr_rdiv u_rdiv (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick(ref_tick),
    .i_clr(r_clr),
    .i_div(i_rdiv),
    .o_pulse(r_pulse)
  );

  pllr_ndiv u_ndiv (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick(vco_rise),
    .i_clr(ab_clr),
    .i_ps_mode(i_ps_mode),
    .i_a(i_a),
    .i_b(i_b),
    .i_b_bypass(i_b_bypass),
    .o_pulse(n_pulse)
  );

  // ********************************
  // delay cells
  // ********************************
  logic [PLLR_DLY_TAPS-1:0] rline_q, rline_d, nline_q, nline_d;
  logic pfd_r_q, pfd_r_d, pfd_n_q, pfd_n_d;

  always_comb begin
    rline_d = {rline_q[PLLR_DLY_TAPS-2:0], r_pulse};
    nline_d = {nline_q[PLLR_DLY_TAPS-2:0], n_pulse};
    pfd_r_d = pllr_tap(rline_d, i_rdly_en, i_rdly); // R22
    pfd_n_d = pllr_tap(nline_d, i_ndly_en, i_ndly); // R22
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rline_q <= '0;
      nline_q <= '0;
      pfd_r_q <= 1'b0;
      pfd_n_q <= 1'b0;
    end else begin
      rline_q <= rline_d;
      nline_q <= nline_d;
      pfd_r_q <= pfd_r_d;
      pfd_n_q <= pfd_n_d;
    end
  end

  assign o_pfd_ref = pfd_r_q;
  assign o_pfd_fb = pfd_n_q;

endmodule

// File: tb/pllr_sw_checker.sv
// port-level assertions for the reference switch and dividers
`timescale 1ns/100ps
module pllr_sw_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // watched inputs
  input wire logic i_pll_pd,
  input wire logic i_diff_en,
  input wire logic i_se_en,
  input wire logic i_primary_pd,
  input wire logic i_secondary_pd,
  input wire logic i_auto_en,
  input wire logic i_deglitch_dis,
  input wire logic i_secondary_reference,
  input wire logic i_rdiv_rst,
  input wire logic i_ab_rst,
  input wire logic i_rab_rst,
  input wire logic [1:0] i_resync_mode,
  input wire logic i_resync_n,
  input wire logic i_rdly_en,
  input wire logic i_ndly_en,
  // watched outputs
  input wire logic o_diff_buf_en,
  input wire logic o_primary_buf_en,
  input wire logic o_secondary_buf_en,
  input wire logic o_on_secondary,
  input wire logic o_primary_missing,
  input wire logic o_pfd_ref,
  input wire logic o_pfd_fb
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // clears are only judged with the taps off, else old pulses may still drain out
  sequence s_rclr; (i_rdiv_rst || i_rab_rst) && !i_rdly_en; endsequence
  sequence s_nclr; (i_ab_rst || i_rab_rst) && !i_ndly_en; endsequence
  sequence s_sync; i_resync_mode != 2'h0 && !i_resync_n && !i_rdly_en && !i_ndly_en; endsequence
  property p_diff_only; o_diff_buf_en |-> $past(i_diff_en && !i_pll_pd); endproperty
  property p_pri_only; o_primary_buf_en |-> $past(i_se_en && !i_diff_en && !i_pll_pd && !i_primary_pd); endproperty
  property p_sec_only; o_secondary_buf_en |-> $past(i_se_en && !i_diff_en && !i_pll_pd && !i_secondary_pd); endproperty
  property p_diff_on; i_diff_en && !i_pll_pd |=> o_diff_buf_en; endproperty
  property p_pri_on; i_se_en && !i_diff_en && !i_pll_pd && !i_primary_pd |=> o_primary_buf_en; endproperty
  property p_no_se; (i_diff_en || !i_se_en) [*3] |-> !o_on_secondary; endproperty
  property p_miss_auto; $rose(o_primary_missing) |-> $past(i_auto_en && i_se_en && !i_diff_en && !i_pll_pd); endproperty
  property p_route; $rose(o_primary_missing) |-> ##[0:24] o_on_secondary; endproperty
  property p_deglitch;
    $rose(o_on_secondary) && !i_deglitch_dis && !$past(i_deglitch_dis) |->
      $past(i_secondary_reference) || $past(i_secondary_reference, 2) || $past(i_secondary_reference, 3);
  endproperty
  property p_rclr; s_rclr [*3] |-> !o_pfd_ref; endproperty
  property p_nclr; s_nclr [*3] |-> !o_pfd_fb; endproperty
  property p_sync; s_sync [*3] |-> !o_pfd_ref && !o_pfd_fb; endproperty
  a_diff_only: assert property (p_diff_only) else $error("diff buffer on while off");
  a_pri_only: assert property (p_pri_only) else $error("primary buffer on while off");
  a_sec_only: assert property (p_sec_only) else $error("secondary buffer on while off");
  a_diff_on: assert property (p_diff_on) else $error("diff buffer not enabled");
  a_pri_on: assert property (p_pri_on) else $error("primary buffer not enabled");
  a_no_se: assert property (p_no_se) else $error("secondary routed outside dual mode");
  a_miss_auto: assert property (p_miss_auto) else $error("missing flag outside auto");
  a_route: assert property (p_route) else $error("secondary not routed after loss");
  a_deglitch: assert property (p_deglitch) else $error("switch with idle target");
  a_rclr: assert property (p_rclr) else $error("reference pulse while cleared");
  a_nclr: assert property (p_nclr) else $error("feedback pulse while cleared");
  a_sync: assert property (p_sync) else $error("pulse while resync held");
endmodule

bind pllr_ref_switch pllr_sw_checker pllr_sw_checker_inst (.*);

// File: tb/pllr_ref_src.sv
// reference sources and feedback oscillator facing the switch
`timescale 1ns/100ps
module pllr_ref_src #(
  parameter int PRI_HALF = 3,
  parameter int SEC_HALF = 5
) (
  // clock
  input wire logic i_clk,
  // run controls
  input wire logic i_pri_run,
  input wire logic i_sec_run,
  input wire logic i_vco_run,
  // source levels
  output logic o_pri,
  output logic o_sec,
  output logic o_vco
);
  int pc = 0;
  int sc = 0;
  initial {o_pri, o_sec, o_vco} = 3'h0;
  // a lost source parks low and restarts from a fixed phase, so latencies repeat
  always @(posedge i_clk) begin
    pc <= i_pri_run ? (pc + 1) % PRI_HALF : 0;
    sc <= i_sec_run ? (sc + 1) % SEC_HALF : 0;
    o_pri <= i_pri_run && (o_pri ^ (pc == PRI_HALF - 1));
    o_sec <= i_sec_run && (o_sec ^ (sc == SEC_HALF - 1));
    o_vco <= i_vco_run && !o_vco;
  end
endmodule

// File: tb/tb_pllr_ref_switch.sv
// self-checking bench for the reference switch and dividers
`timescale 1ns/100ps
module tb_pllr_ref_switch import pllr_pkg::*; ();
  logic i_clk = 0, i_rst_n = 0, i_pll_pd = 0, i_diff_en = 0, i_se_en = 0, i_primary_pd = 0;
  logic i_secondary_pd = 0, i_auto_en = 0, i_stay_secondary = 0, i_revert_manual = 0, i_sel_use_pin = 0;
  logic i_sel_reg = 0, i_sel_pin = 0, i_deglitch_dis = 0, i_b_bypass = 0, i_rdiv_rst = 0, i_ab_rst = 0;
  logic i_rab_rst = 0, i_resync_n = 1, i_rdly_en = 0, i_ndly_en = 0, pri_run = 1, sec_run = 1, vco_run = 1;
  logic [PLLR_RDIV_W-1:0] i_rdiv = 14'h0001;
  logic [2:0] i_ps_mode = 3'h0, i_rdly = 3'h0, i_ndly = 3'h0;
  logic [PLLR_A_W-1:0] i_a = 6'h00;
  logic [PLLR_B_W-1:0] i_b = 13'h0003;
  logic [1:0] i_resync_mode = 2'h0;
  wire logic i_primary_reference, i_secondary_reference, i_vco, i_reference_input_pin;
  wire logic o_diff_buf_en, o_primary_buf_en, o_secondary_buf_en, o_on_secondary, o_primary_missing;
  wire logic o_pfd_ref, o_pfd_fb;
  wire logic [1:0] flags = {o_primary_missing, o_on_secondary};
  wire logic [1:0] pls = {o_pfd_fb, o_pfd_ref};
  int n_fail = 0;
  int checked = 0;
  assign i_reference_input_pin = i_primary_reference;
  always #4 i_clk = ~i_clk;
  pllr_ref_switch pllr_ref_switch_inst (.*);
  pllr_ref_src pllr_ref_src_inst (.i_clk(i_clk), .i_pri_run(pri_run), .i_sec_run(sec_run), .i_vco_run(vco_run),
    .o_pri(i_primary_reference), .o_sec(i_secondary_reference), .o_vco(i_vco));
  // ********
  // helpers
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wait_on(input int i, input logic v, input int lim, input string nm);
    int k = 0;
    while (flags[i] !== v && k < lim) begin
      cyc(1);
      k++;
    end
    chk(nm, flags[i], v);
  endtask
  // cycles between two successive pulses of one divider
  task automatic gap(input int i, output int n);
    int k = 0;
    n = 0;
    while (pls[i] !== 1'b1 && k < 400) begin
      cyc(1);
      k++;
    end
    cyc(1);
    while (pls[i] !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    n++;
  endtask
  task automatic bufs(input logic [4:0] c, input logic [2:0] e);
    {i_pll_pd, i_diff_en, i_se_en, i_primary_pd, i_secondary_pd} <= c;
    cyc(3);
    chk("bufs", {o_diff_buf_en, o_primary_buf_en, o_secondary_buf_en}, e);
  endtask
  // cycles from a clean restart of the sources to the first pulse
  task automatic lat(input int i, output int n);
    {pri_run, vco_run, i_rab_rst} <= 3'h1;
    cyc(20);
    {pri_run, vco_run, i_rab_rst} <= 3'h6;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (pls[i] !== 1'b1 && n < 100);
  endtask
  task automatic lose(input logic back);
    pri_run <= 0;
    wait_on(1, 1, 24, "missing");
    wait_on(0, 1, 16, "route_sec");
    pri_run <= 1;
    cyc(80);
    chk("return", o_on_secondary, !back);
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_buffers;
    chk("bufs_reset", {o_diff_buf_en, o_primary_buf_en, o_secondary_buf_en}, 3'h0);
    bufs(5'h04, 3'h3);
    bufs(5'h06, 3'h1);
    bufs(5'h05, 3'h2);
    bufs(5'h0C, 3'h4);
    bufs(5'h1C, 3'h0);
    bufs(5'h14, 3'h0);
    bufs(5'h04, 3'h3);
    $display("test buffers done");
  endtask
  task automatic t_rdiv;
    int n;
    logic [13:0] r[4] = '{14'h0000, 14'h0001, 14'h0003, 14'h0005};
    foreach (r[k]) begin
      i_rdiv <= r[k];
      gap(0, n);
      gap(0, n);
      chk("rdiv_gap", n, (r[k] > 1 ? r[k] : 1) * 6);
    end
    i_rdiv <= 14'h0001;
    $display("test rdiv done");
  endtask
  task automatic t_ndiv;
    int n;
    logic [2:0] md[10] = '{PLLR_PS_FD1, PLLR_PS_FD2, PLLR_PS_FD3, PLLR_PS_FD2, PLLR_PS_DM2,
      PLLR_PS_DM2, PLLR_PS_DM4, PLLR_PS_DM8, PLLR_PS_DM16, PLLR_PS_DM32};
    int a[10] = '{5, 0, 0, 0, 1, 0, 1, 2, 1, 0};
    int b[10] = '{4, 3, 4, 0, 3, 5, 3, 3, 3, 3};
    int nn[10] = '{4, 6, 12, 2, 7, 10, 13, 26, 49, 96};
    foreach (md[k]) begin
      i_ps_mode <= md[k];
      i_a <= a[k][5:0];
      i_b <= b[k][12:0];
      i_b_bypass <= (k == 3);
      gap(1, n);
      gap(1, n);
      chk("ndiv_gap", n, nn[k] * 2);
    end
    {i_ps_mode, i_a, i_b, i_b_bypass} <= {PLLR_PS_FD1, 6'h00, 13'h0003, 1'b0};
    $display("test ndiv done");
  endtask
  task automatic t_clears;
    int cr, cf;
    for (int k = 0; k < 7; k++) begin
      {i_rdiv_rst, i_ab_rst, i_rab_rst} <= {k == 0, k == 1, k == 2};
      i_resync_mode <= (k > 2 && k < 6) ? 2'(k - 2) : 2'h0;
      i_resync_n <= k < 3;
      cyc(12);
      cr = 0;
      cf = 0;
      repeat (40) begin
        cyc(1);
        cr += int'(pls[0] === 1'b1);
        cf += int'(pls[1] === 1'b1);
      end
      chk("ref_runs", cr != 0, k == 1 || k == 6);
      chk("fb_runs", cf != 0, k == 0 || k == 6);
    end
    {i_rdiv_rst, i_ab_rst, i_rab_rst, i_resync_n} <= 4'h1;
    $display("test clears done");
  endtask
  task automatic t_delay;
    int n0, n1;
    for (int i = 0; i < 2; i++) begin
      lat(i, n0);
      {i_rdly_en, i_ndly_en, i_rdly, i_ndly} <= 8'hDE;
      lat(i, n1);
      chk("delay", n1 - n0, i ? 6 : 3);
      {i_rdly_en, i_ndly_en} <= 2'h0;
    end
    $display("test delay done");
  endtask
  task automatic t_manual;
    sec_run <= 0;
    i_sel_reg <= 1;
    cyc(30);
    chk("held", o_on_secondary, 1'b0);
    sec_run <= 1;
    wait_on(0, 1, 30, "to_sec");
    {i_sel_use_pin, i_sel_pin} <= 2'h2;
    wait_on(0, 0, 30, "pin_pri");
    {sec_run, i_deglitch_dis, i_sel_pin} <= 3'h3;
    wait_on(0, 1, 8, "no_deglitch");
    i_diff_en <= 1;
    wait_on(0, 0, 8, "diff_mode");
    {i_diff_en, sec_run, i_deglitch_dis, i_sel_use_pin, i_sel_pin, i_sel_reg} <= 6'h10;
    cyc(10);
    $display("test manual done");
  endtask
  task automatic t_auto;
    i_auto_en <= 1;
    cyc(10);
    lose(1);
    chk("miss_clr", o_primary_missing, 1'b0);
    i_stay_secondary <= 1;
    lose(0);
    i_auto_en <= 0;
    wait_on(0, 0, 30, "reselect");
    {i_auto_en, i_stay_secondary, i_revert_manual} <= 3'h5;
    cyc(10);
    lose(0);
    i_auto_en <= 0;
    wait_on(0, 0, 30, "reselect2");
    $display("test auto done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    cyc(10);
    i_rst_n <= 1;
    cyc(2);
    t_buffers;
    t_rdiv;
    t_ndiv;
    t_clears;
    t_delay;
    t_manual;
    t_auto;
    wrap_up;
  end
  // the tests need about 2500 cycles
  initial begin
    cyc(20000);
    n_fail++;
    wrap_up;
  end
endmodule
